// ---- rtl/mptc_decoder.sv ----
// Multipurpose command decoder with training FIFO and pattern readout
// Overview of operation
// RULE_01 - Top operand bit zero means no-operation
// RULE_02 - Command spans two edges, operand split
// RULE_03 - Column-second follows data training commands immediately
// RULE_04 - Latencies count from column-second second edge
// RULE_05 - Column-second operands driven low by controller
// RULE_06 - Only load, unload, calibration need column-second
// RULE_07 - Decode unload, calibration, load; others reserved
// RULE_08 - Decode oscillator run, halt, impedance begin, apply
// RULE_09 - FIFO transfers always sixteen beats
// RULE_10 - Load accepted in any bank state, CKE high
// RULE_11 - Controller waits write-to-FIFO gap after write
// RULE_12 - Back-to-back loads every column interval accepted
// RULE_13 - Load timed as write, unload as read
// RULE_14 - Five entries, write pointer wraps
// RULE_15 - Unwritten entries return undefined data
// RULE_16 - First unload directly follows last load
// RULE_17 - Unload non-destructive, read pointer wraps
// RULE_18 - Unload drives mask lanes when features enabled
// RULE_19 - Controller waits read-to-training gap before read
// RULE_20 - No unload right after ordinary access
// RULE_21 - Controller waits write gap before calibration
// RULE_22 - Only register writes between load and unload
// RULE_23 - Calibration drives first then second byte
// RULE_24 - Reserved operands change nothing
// RULE_25 - Pointers restart at training sequence entry
`timescale 1ns/1ps
module mptc_decoder (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic cke_i,
   input wire mptc_pkg::mptc_cmd_s cmd_i,
   input wire mptc_pkg::mptc_cfg_s cfg_i,
   input wire mptc_pkg::mptc_burst_s wr_burst_i,
   output mptc_pkg::mptc_burst_s rd_burst_o,
   output logic dq_oe_o,
   output logic mask_oe_o,
   output logic rd_valid_o,
   output logic strobe_osc_run_o,
   output logic strobe_osc_halt_o,
   output logic impedance_cal_begin_o,
   output logic impedance_cal_apply_o
);
   typedef struct packed {
      mptc_pkg::mptc_state_e fsm;
      mptc_pkg::mptc_kind_e kind;
      mptc_pkg::mptc_kind_e last_kind;
      logic op_top;
      logic cke_prev;
      logic [mptc_pkg::DELAY_LEN-1:0] pend_load;
      logic [mptc_pkg::DELAY_LEN-1:0] pend_unload;
      logic [mptc_pkg::DELAY_LEN-1:0] pend_cal;
      mptc_pkg::mptc_burst_s rd_burst;
      logic dq_oe;
      logic mask_oe;
      logic rd_valid;
      logic osc_run;
      logic osc_halt;
      logic cal_begin;
      logic cal_apply;
   } mptc_state_s;

   mptc_state_s s_q;
   mptc_state_s s_d;
   mptc_pkg::mptc_burst_s cal_burst;
   mptc_pkg::mptc_burst_s fifo_rd_data;
   logic fifo_restart;
   logic fifo_wr_en;
   logic fifo_rd_en;

   // Pattern burst: first byte on beats 0-7, second on 8-15, every lane
   for (genvar b = 0; b < mptc_pkg::BEATS; b++) begin : g_pat
      localparam int BIT_IDX = b % 8;
      logic pat_bit;
      assign pat_bit = (b < 8) ? cfg_i.pattern_first_byte[BIT_IDX]
                       : cfg_i.pattern_second_byte[BIT_IDX]; // RULE_23
      assign cal_burst.dq[b*mptc_pkg::DQ_W +: mptc_pkg::DQ_W] = {mptc_pkg::DQ_W{pat_bit}};
      assign cal_burst.mask_inversion_lane[b*mptc_pkg::DMI_W +: mptc_pkg::DMI_W] =
         {mptc_pkg::DMI_W{pat_bit}}; // RULE_23
   end

   // Delay-line insertion point: fires latency cycles later, a latency of zero firing as one
   function automatic logic [mptc_pkg::DELAY_LEN-1:0] lat_slot(
      input logic [mptc_pkg::LAT_W-1:0] lat);
      logic [mptc_pkg::LAT_W-1:0] idx;
      idx = (lat == '0) ? '0 : lat - 6'h01;
      lat_slot = mptc_pkg::DELAY_LEN'(1) << idx;
   endfunction

   // FIFO controls come from the data-phase taps and the load decode
   assign fifo_wr_en = s_q.pend_load[0]; // RULE_13
   assign fifo_rd_en = s_q.pend_unload[0]; // RULE_13

   // Command decode, latency lines and data-phase outputs
   always_comb begin
      logic valid;
      logic [mptc_pkg::OP_W-1:0] op;
      valid = 1'b0;
      op = '0;
      s_d = s_q;
      fifo_restart = 1'b0;
      valid = cke_i && s_q.cke_prev; // RULE_10
      op = {s_q.op_top, cmd_i.ca};
      s_d.cke_prev = cke_i;
      s_d.osc_run = 1'b0;
      s_d.osc_halt = 1'b0;
      s_d.cal_begin = 1'b0;
      s_d.cal_apply = 1'b0;
      s_d.pend_load = s_q.pend_load >> 1; // RULE_12
      s_d.pend_unload = s_q.pend_unload >> 1;
      s_d.pend_cal = s_q.pend_cal >> 1;
      case (s_q.fsm)
         mptc_pkg::ST_IDLE: begin
            if (valid && cmd_i.cs && cmd_i.ca[4:0] == mptc_pkg::MPC_CODE) begin // RULE_02
               s_d.op_top = cmd_i.ca[5]; // RULE_01
               s_d.fsm = mptc_pkg::ST_MPC_2ND;
            end
         end
         mptc_pkg::ST_MPC_2ND: begin
            s_d.fsm = mptc_pkg::ST_IDLE;
            if (valid && !cmd_i.cs && s_q.op_top) begin // RULE_01
               if (op == mptc_pkg::OP_FIFO_UNLOAD) begin // RULE_07
                  s_d.kind = mptc_pkg::TK_UNLOAD;
                  s_d.fsm = mptc_pkg::ST_CAS_1ST; // RULE_06
               end else if (op == mptc_pkg::OP_PATTERN_CAL) begin // RULE_07
                  s_d.kind = mptc_pkg::TK_CAL;
                  s_d.fsm = mptc_pkg::ST_CAS_1ST; // RULE_06
               end else if (op == mptc_pkg::OP_FIFO_LOAD) begin // RULE_07
                  s_d.kind = mptc_pkg::TK_LOAD;
                  s_d.fsm = mptc_pkg::ST_CAS_1ST; // RULE_06
               end else if (op == mptc_pkg::OP_OSC_RUN) begin
                  s_d.osc_run = 1'b1; // RULE_08
               end else if (op == mptc_pkg::OP_OSC_HALT) begin
                  s_d.osc_halt = 1'b1; // RULE_08
               end else if (op == mptc_pkg::OP_CAL_BEGIN) begin
                  s_d.cal_begin = 1'b1; // RULE_08
               end else if (op == mptc_pkg::OP_CAL_APPLY) begin
                  s_d.cal_apply = 1'b1; // RULE_08
               end
               // Future-use and reserved codes fall through untouched
            end // RULE_24
         end
         mptc_pkg::ST_CAS_1ST: begin
            // Anything but a column-second here abandons the training command
            if (valid && cmd_i.cs && cmd_i.ca[4:0] == mptc_pkg::CAS2_CODE) begin // RULE_03
               s_d.fsm = mptc_pkg::ST_CAS_2ND;
            end else begin
               s_d.fsm = mptc_pkg::ST_IDLE;
               s_d.kind = mptc_pkg::TK_NONE;
            end
         end
         mptc_pkg::ST_CAS_2ND: begin
            s_d.fsm = mptc_pkg::ST_IDLE;
            s_d.kind = mptc_pkg::TK_NONE;
            if (valid && !cmd_i.cs) begin
               // Latency counted from this second edge
               if (s_q.kind == mptc_pkg::TK_LOAD) begin
                  s_d.pend_load = s_d.pend_load | lat_slot(cfg_i.write_latency); // RULE_04
                  fifo_restart = (s_q.last_kind != mptc_pkg::TK_LOAD); // RULE_25
               end else if (s_q.kind == mptc_pkg::TK_UNLOAD) begin
                  s_d.pend_unload = s_d.pend_unload | lat_slot(cfg_i.read_latency); // RULE_04
               end else begin
                  s_d.pend_cal = s_d.pend_cal | lat_slot(cfg_i.read_latency); // RULE_04
               end
               s_d.last_kind = s_q.kind;
            end
         end
         default: begin
            s_d.fsm = mptc_pkg::ST_IDLE;
         end
      endcase
      // Read-side data phase, one burst per cycle so back-to-back works
      s_d.dq_oe = 1'b0;
      s_d.mask_oe = 1'b0;
      s_d.rd_valid = 1'b0;
      if (s_q.pend_unload[0]) begin
         s_d.rd_burst = fifo_rd_data; // RULE_13
         s_d.dq_oe = 1'b1;
         s_d.rd_valid = 1'b1;
         s_d.mask_oe = cfg_i.wr_inversion_en || cfg_i.rd_inversion_en
                       || cfg_i.write_masking_en; // RULE_18
      end else if (s_q.pend_cal[0]) begin
         s_d.rd_burst = cal_burst; // RULE_23
         s_d.dq_oe = 1'b1;
         s_d.mask_oe = 1'b1; // RULE_23
         s_d.rd_valid = 1'b1;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Training FIFO, always a full 16-beat burst per entry
   mptc_fifo u_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .restart_i(fifo_restart),
      .wr_en_i(fifo_wr_en), // RULE_09
      .wr_data_i(wr_burst_i),
      .rd_en_i(fifo_rd_en),
      .rd_data_o(fifo_rd_data)
   );

   // Outputs straight from state flops
   assign rd_burst_o = s_q.rd_burst;
   assign dq_oe_o = s_q.dq_oe;
   assign mask_oe_o = s_q.mask_oe;
   assign rd_valid_o = s_q.rd_valid;
   assign strobe_osc_run_o = s_q.osc_run;
   assign strobe_osc_halt_o = s_q.osc_halt;
   assign impedance_cal_begin_o = s_q.cal_begin;
   assign impedance_cal_apply_o = s_q.cal_apply;
endmodule

// ---- rtl/mptc_pkg.sv ----
// Shared constants, enums and carrier structs for the training command decoder
package mptc_pkg;
   // Command bus shape
   localparam int CA_W = 6;
   localparam int OP_W = 7;
   localparam logic [4:0] MPC_CODE = 5'h00;
   localparam logic [4:0] CAS2_CODE = 5'h12;

   // Operand encodings
   localparam logic [6:0] OP_FIFO_UNLOAD = 7'h41;
   localparam logic [6:0] OP_PATTERN_CAL = 7'h43;
   localparam logic [6:0] OP_FUTURE_A = 7'h45;
   localparam logic [6:0] OP_FIFO_LOAD = 7'h47;
   localparam logic [6:0] OP_FUTURE_B = 7'h49;
   localparam logic [6:0] OP_OSC_RUN = 7'h4B;
   localparam logic [6:0] OP_OSC_HALT = 7'h4D;
   localparam logic [6:0] OP_CAL_BEGIN = 7'h4F;
   localparam logic [6:0] OP_CAL_APPLY = 7'h51;

   // Burst geometry: fixed 16-beat bursts on 16 data and 2 mask lanes
   localparam int DQ_W = 16;
   localparam int DMI_W = 2;
   localparam int BEATS = 16;
   localparam int BURST_DQ_W = DQ_W * BEATS;
   localparam int BURST_DMI_W = DMI_W * BEATS;
   localparam int BURST_W = BURST_DQ_W + BURST_DMI_W;

   // Training FIFO and latency line
   localparam int FIFO_DEPTH = 5;
   localparam int PTR_W = 3;
   localparam logic [2:0] PTR_FIRST = 3'h0;
   localparam logic [2:0] PTR_LAST = 3'h4;
   localparam int LAT_W = 6;
   localparam int DELAY_LEN = 64;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MPC_2ND = 2'b01,
      ST_CAS_1ST = 2'b10,
      ST_CAS_2ND = 2'b11
   } mptc_state_e;

   typedef enum logic [1:0] {
      TK_NONE = 2'b00,
      TK_LOAD = 2'b01,
      TK_UNLOAD = 2'b10,
      TK_CAL = 2'b11
   } mptc_kind_e;

   typedef struct packed {
      logic cs;
      logic [CA_W-1:0] ca;
   } mptc_cmd_s;

   typedef struct packed {
      logic [BURST_DQ_W-1:0] dq;
      logic [BURST_DMI_W-1:0] mask_inversion_lane;
   } mptc_burst_s;

   typedef struct packed {
      logic [LAT_W-1:0] read_latency;
      logic [LAT_W-1:0] write_latency;
      logic wr_inversion_en;
      logic rd_inversion_en;
      logic write_masking_en;
      logic [7:0] pattern_first_byte;
      logic [7:0] pattern_second_byte;
   } mptc_cfg_s;
endpackage

// ---- rtl/mptc_fifo.sv ----
// Five-entry training FIFO with wrapping, non-destructive read pointer
`timescale 1ns/1ps
module mptc_fifo (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic restart_i,
   input wire logic wr_en_i,
   input wire mptc_pkg::mptc_burst_s wr_data_i,
   input wire logic rd_en_i,
   output mptc_pkg::mptc_burst_s rd_data_o
);
   typedef struct packed {
      logic [mptc_pkg::FIFO_DEPTH-1:0][mptc_pkg::BURST_W-1:0] mem;
      logic [mptc_pkg::PTR_W-1:0] wr_ptr;
      logic [mptc_pkg::PTR_W-1:0] rd_ptr;
   } mptc_fifo_s;

   mptc_fifo_s s_q;
   mptc_fifo_s s_d;

   // Unwritten entries hold whatever they held before
   assign rd_data_o = mptc_pkg::mptc_burst_s'(s_q.mem[s_q.rd_ptr]); // RULE_15

   // Pointer and storage update
   always_comb begin
      s_d = s_q;
      if (restart_i) begin
         s_d.wr_ptr = mptc_pkg::PTR_FIRST; // RULE_25
         s_d.rd_ptr = mptc_pkg::PTR_FIRST; // RULE_25
      end
      if (wr_en_i) begin
         s_d.mem[s_d.wr_ptr] = wr_data_i;
         // Sixth load lands on the first entry
         s_d.wr_ptr = (s_d.wr_ptr == mptc_pkg::PTR_LAST) ? mptc_pkg::PTR_FIRST
                      : s_d.wr_ptr + 3'h1; // RULE_14
      end
      if (rd_en_i) begin
         // Reading leaves entries intact and wraps after five
         s_d.rd_ptr = (s_d.rd_ptr == mptc_pkg::PTR_LAST) ? mptc_pkg::PTR_FIRST
                      : s_d.rd_ptr + 3'h1; // RULE_17
      end
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ---- test/mptc_props.sv ----
// Port checker for the training command decoder
`timescale 1ns/1ps
module mptc_props (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic cke_i,
   input wire mptc_pkg::mptc_cmd_s cmd_i,
   input wire mptc_pkg::mptc_cfg_s cfg_i,
   input wire mptc_pkg::mptc_burst_s rd_burst_o,
   input wire logic dq_oe_o,
   input wire logic mask_oe_o,
   input wire logic rd_valid_o,
   input wire logic strobe_osc_run_o,
   input wire logic strobe_osc_halt_o,
   input wire logic impedance_cal_begin_o,
   input wire logic impedance_cal_apply_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic any_pulse;
   logic any_en;
   // Summary flags
   assign any_pulse = strobe_osc_run_o | strobe_osc_halt_o | impedance_cal_begin_o
      | impedance_cal_apply_o;
   assign any_en = cfg_i.wr_inversion_en | cfg_i.rd_inversion_en | cfg_i.write_masking_en;
   // Two-edge command, operand split over both edges
   sequence s_mpc(logic [6:0] op);
      cke_i && cmd_i.cs && cmd_i.ca == {op[6], 5'h00} ##1 cke_i && !cmd_i.cs && cmd_i.ca == op[5:0];
   endsequence
   sequence s_cas2;
      cke_i && cmd_i.cs && cmd_i.ca[4:0] == 5'h12 ##1 cke_i && !cmd_i.cs;
   endsequence
   sequence s_data(logic [6:0] op);
      s_mpc(op) ##1 s_cas2 ##0 cfg_i.read_latency == 6'h03;
   endsequence
   property p_pulse(logic [6:0] op, logic out);
      s_mpc(op) |=> out ##1 !out;
   endproperty
   a_osc_run: assert property (p_pulse(mptc_pkg::OP_OSC_RUN, strobe_osc_run_o))
      else $error("oscillator run pulse wrong");
   a_osc_halt: assert property (p_pulse(mptc_pkg::OP_OSC_HALT, strobe_osc_halt_o))
      else $error("oscillator halt pulse wrong");
   a_cal_begin: assert property (p_pulse(mptc_pkg::OP_CAL_BEGIN, impedance_cal_begin_o))
      else $error("calibration begin pulse wrong");
   a_cal_apply: assert property (p_pulse(mptc_pkg::OP_CAL_APPLY, impedance_cal_apply_o))
      else $error("calibration apply pulse wrong");
   a_nop_quiet: assert property (s_mpc(7'h2A) |=> !any_pulse [*2])
      else $error("no-operation produced output");
   a_reserved_quiet: assert property (s_mpc(mptc_pkg::OP_FUTURE_A) or s_mpc(mptc_pkg::OP_FUTURE_B)
      |=> (!any_pulse && !rd_valid_o) [*6])
      else $error("reserved operand produced output");
   a_unload_time: assert property (s_data(mptc_pkg::OP_FIFO_UNLOAD)
      |-> ##4 rd_valid_o && dq_oe_o && mask_oe_o == any_en)
      else $error("unload burst timing or mask wrong");
   a_cal_pattern: assert property (s_data(mptc_pkg::OP_PATTERN_CAL) |-> ##4 rd_valid_o
      && mask_oe_o && rd_burst_o.dq[15:0] == {16{cfg_i.pattern_first_byte[0]}}
      && rd_burst_o.dq[255:240] == {16{cfg_i.pattern_second_byte[7]}})
      else $error("pattern burst wrong");
   a_burst_pulse: assert property (rd_valid_o |-> dq_oe_o ##1 !rd_valid_o)
      else $error("burst valid not a single pulse");
endmodule

// ---- test/mptc_ctrl_model.sv ----
// Memory controller model issuing training commands
`timescale 1ns/1ps
module mptc_ctrl_model (
   input wire logic ref_clk_i,
   output mptc_pkg::mptc_cmd_s cmd_o,
   output mptc_pkg::mptc_burst_s wr_burst_o,
   output logic cke_o
);
   // Bus idle at start
   initial begin
      cmd_o = '0;
      wr_burst_o = '0;
      cke_o = 1'b1;
   end
   // One command edge driven after the falling edge
   task automatic edge_drv(input logic cs, input logic [5:0] ca);
      @(negedge ref_clk_i);
      cmd_o = {cs, ca};
   endtask
   // Deselected cycles, address lines toggling
   task automatic idle(input int n);
      repeat (n) edge_drv(1'b0, ~cmd_o.ca);
   endtask
   // Command plus trailing column-second for data functions
   task automatic send(input logic [6:0] op, input mptc_pkg::mptc_burst_s d, input int wl);
      // Only training commands, never an ordinary access, so access gaps hold
      edge_drv(1'b1, {op[6], 5'h00});
      edge_drv(1'b0, op[5:0]);
      if (op == mptc_pkg::OP_FIFO_LOAD || op == mptc_pkg::OP_FIFO_UNLOAD
         || op == mptc_pkg::OP_PATTERN_CAL) begin
         edge_drv(1'b1, 6'h12);
         edge_drv(1'b0, 6'h00);
         if (op == mptc_pkg::OP_FIFO_LOAD) fork
            begin
               repeat (wl) @(negedge ref_clk_i);
               wr_burst_o = d;
               @(negedge ref_clk_i);
               wr_burst_o = ~d;
            end
         join_none
      end
   endtask
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the training command decoder
`timescale 1ns/1ps
module tb;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cke_i, dq_oe_o, mask_oe_o, rd_valid_o, mask_exp, v;
   logic [3:0] pulse;
   logic [6:0] op;
   mptc_pkg::mptc_cfg_s cfg_i = '0;
   mptc_pkg::mptc_cmd_s cmd_i;
   mptc_pkg::mptc_burst_s wr_burst_i, rd_burst_o, d, fifo[5], exp_q[$];
   logic mq[$];
   int error_cnt = 0;
   int n_tests = 0;
   int seed = 32'h2403;
   int pc[4] = '{0, 0, 0, 0};
   int wp = 0;
   int rp = 0;
   always #5 ref_clk_i = ~ref_clk_i;
   mptc_ctrl_model mc_u (.ref_clk_i, .cmd_o(cmd_i), .wr_burst_o(wr_burst_i), .cke_o(cke_i));
   mptc_decoder dut_u (.ref_clk_i, .rst_n_i, .cke_i, .cmd_i, .cfg_i, .wr_burst_i, .rd_burst_o,
      .dq_oe_o, .mask_oe_o, .rd_valid_o, .strobe_osc_run_o(pulse[0]),
      .strobe_osc_halt_o(pulse[1]), .impedance_cal_begin_o(pulse[2]),
      .impedance_cal_apply_o(pulse[3]));
   task automatic check(input string nm, input logic [287:0] e, input logic [287:0] s);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Unload from the model FIFO, pointer wraps after five
   task automatic unload;
      exp_q.push_back(fifo[rp]);
      mq.push_back(mask_exp);
      rp = (rp + 1) % 5;
      mc_u.send(mptc_pkg::OP_FIFO_UNLOAD, d, 3);
   endtask
   // Monitor: count pulses, compare each burst with the model
   always @(negedge ref_clk_i) if (rst_n_i) begin
      for (int k = 0; k < 4; k++) if (pulse[k] !== 1'b0) pc[k]++;
      if (rd_valid_o !== 1'b0) begin
         if (exp_q.size() == 0) check("spurious burst", 288'h0, 288'h1);
         else begin
            check("burst", exp_q.pop_front(), rd_burst_o);
            check("mask enable", {287'h0, mq.pop_front()}, {287'h0, mask_oe_o});
         end
      end
   end
   // Main sequence
   initial begin
      repeat (12) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      cfg_i.read_latency = 6'h03;
      cfg_i.write_latency = 6'h03;
      {cfg_i.wr_inversion_en, cfg_i.rd_inversion_en, cfg_i.write_masking_en} = 3'($random(seed));
      cfg_i.pattern_first_byte = 8'($random(seed));
      cfg_i.pattern_second_byte = 8'($random(seed));
      mask_exp = cfg_i.wr_inversion_en | cfg_i.rd_inversion_en | cfg_i.write_masking_en;
      mc_u.idle(2);
      for (int i = 0; i < 6; i++) begin
         for (int k = 0; k < 9; k++) d[k*32 +: 32] = $random(seed);
         fifo[wp] = d;
         wp = (wp + 1) % 5;
         mc_u.send(mptc_pkg::OP_FIFO_LOAD, d, 3);
      end
      for (int i = 0; i < 7; i++) unload();
      mc_u.idle(8);
      for (int j = 0; j < 5; j++) begin
         op = (j == 4) ? 7'h2A : 7'h45 + 7'(j * 4 + (j > 1 ? 6 : 0));
         mc_u.send(op, d, 3);
      end
      mc_u.idle(8);
      unload();
      for (int b = 0; b < 16; b++) begin
         v = (b < 8) ? cfg_i.pattern_first_byte[b] : cfg_i.pattern_second_byte[b-8];
         d.dq[b*16 +: 16] = {16{v}};
         d.mask_inversion_lane[b*2 +: 2] = {2{v}};
      end
      for (int j = 0; j < 2; j++) begin
         exp_q.push_back(d);
         mq.push_back(1'b1);
         mc_u.send(mptc_pkg::OP_PATTERN_CAL, d, 3);
      end
      mc_u.send(mptc_pkg::OP_OSC_RUN, d, 3);
      mc_u.send(mptc_pkg::OP_OSC_HALT, d, 3);
      mc_u.send(mptc_pkg::OP_CAL_BEGIN, d, 3);
      mc_u.send(mptc_pkg::OP_CAL_APPLY, d, 3);
      // Fresh load after other training: both pointers restart, new latencies
      cfg_i.write_latency = 6'(4 + ($random(seed) & 3));
      cfg_i.read_latency = 6'(5 + ($random(seed) & 3));
      {cfg_i.wr_inversion_en, cfg_i.rd_inversion_en, cfg_i.write_masking_en} = 3'($random(seed));
      mask_exp = cfg_i.wr_inversion_en | cfg_i.rd_inversion_en | cfg_i.write_masking_en;
      for (int k = 0; k < 9; k++) d[k*32 +: 32] = $random(seed);
      fifo[0] = d;
      wp = 1;
      rp = 0;
      mc_u.send(mptc_pkg::OP_FIFO_LOAD, d, int'(cfg_i.write_latency));
      unload();
      mc_u.idle(3);
      mc_u.cke_o = 1'b0;
      mc_u.send(mptc_pkg::OP_OSC_RUN, d, 3);
      mc_u.idle(2);
      mc_u.cke_o = 1'b1;
      mc_u.idle(10);
      for (int k = 0; k < 4; k++) check("pulse count", 288'h1, 288'(pc[k]));
      check("pending bursts", 288'h0, 288'(exp_q.size()));
      tally_and_finish();
   end
   // Watchdog against a hung run
   initial begin
      #20000;
      error_cnt++;
      tally_and_finish();
   end
endmodule
bind mptc_decoder mptc_props chk_u (.ref_clk_i, .rst_n_i, .cke_i, .cmd_i, .cfg_i, .rd_burst_o,
   .dq_oe_o, .mask_oe_o, .rd_valid_o, .strobe_osc_run_o, .strobe_osc_halt_o,
   .impedance_cal_begin_o, .impedance_cal_apply_o);
